// ===== verilog/mrl_regs.sv
`timescale 1ns/1ps
module mrl_regs #(
  parameter logic [7:0] DEVICE_IDENTIFIER_VAL = 8'h5A,  // Arbitrary value
  parameter logic [7:0] MAKER_ID_VAL  = 8'h3C,  // Arbitrary value
  parameter logic [7:0] REVISION_VAL  = 8'h01   // Arbitrary value
) (
  // Clock and reset
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // Write address
  input  wire logic [mrl_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic [2:0]                  s_axi_awprot,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  // Write data
  input  wire logic [mrl_pkg::DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  // Write response
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  // Read address
  input  wire logic [mrl_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic [2:0]                  s_axi_arprot,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  // Read data
  output logic [mrl_pkg::DATA_W-1:0]       s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  // Converter results
  input  wire mrl_pkg::mrl_conv_s          conv_in,
  // Interrupt
  output logic                             irq_out
);
  import mrl_pkg::*;

  function automatic logic [1:0] grp_of(input logic [3:0] ch);
    if (ch < GRP1_FIRST) begin
      grp_of = 2'd0;
    end else if (ch < GRP2_FIRST) begin
      grp_of = 2'd1;
    end else begin
      grp_of = 2'd2;
    end
  endfunction : grp_of

  function automatic logic exceeds(input logic [7:0] v, input logic [7:0] lim,
                                   input logic sg);
    exceeds = sg ? ($signed(v) > $signed(lim)) : (v > lim);
  endfunction : exceeds

  // Registers
  logic [7:0]         cfg1_r;
  logic [7:0]         cfg2_r;
  logic [7:0]         cfg3_r;
  logic [7:0]         mask1_r;
  logic [7:0]         mask2_r;
  logic [7:0]         off_int_r;
  logic [7:0]         off_ext_r;
  logic [7:0]         flags1_r;
  logic [7:0]         flags2_r;
  logic [7:0]         flags1_nxt;
  logic [7:0]         flags2_nxt;
  logic [7:0]         upper_r [NCH];
  logic [7:0]         lower_r [NCH];
  logic [7:0]         snap_r  [NCH];
  logic [9:0]         res_r   [NCH];
  logic [7:0]         shown_hi [NCH];
  logic               fault_r;
  logic [NGRP-1:0]    frz_r;
  logic [NGRP-1:0]    frz_nxt;
  logic [NGRP-1:0]    lock_grp;

  // Bus state
  logic                 aw_have_r;
  logic                 w_have_r;
  logic [ADDR_W-1:0]    awaddr_r;
  logic [7:0]           wbyte_r;
  logic                 wstrb0_r;
  logic                 awready_r;
  logic                 wready_r;
  logic                 bvalid_r;
  logic                 arready_r;
  logic                 rvalid_r;
  logic [DATA_W-1:0]    rdata_r;
  logic                 irq_r;

  // Write decode
  wire         aw_take  = s_axi_awvalid && awready_r;
  wire         w_take   = s_axi_wvalid && wready_r;
  wire         wr_fire  = aw_have_r && w_have_r && !bvalid_r;
  wire         wr_en    = wr_fire && wstrb0_r;
  wire [7:0]   wr_idx   = awaddr_r[ADDR_W-1:2];
  wire         swrst    = wr_en && (wr_idx == IDX_CFG_THREE) && wbyte_r[CFG3_SWRST_BIT];

  // Read decode
  wire         rd_fire  = s_axi_arvalid && arready_r;
  wire [7:0]   rd_idx   = s_axi_araddr[ADDR_W-1:2];
  wire [7:0]   low_off  = rd_idx - IDX_LOW_INT_SUPPLY;
  wire [7:0]   high_off = rd_idx - IDX_HIGH_SUPPLY;
  wire [1:0]   low_g    = low_off[1:0];
  wire [3:0]   high_ch  = high_off[3:0];
  wire [1:0]   high_g   = grp_of(high_ch);
  wire         in_low   = (rd_idx >= IDX_LOW_INT_SUPPLY) && (rd_idx <= IDX_LOW_IN5TO8);
  wire         in_high  = (rd_idx >= IDX_HIGH_SUPPLY) && (rd_idx <= IDX_HIGH_IN8);
  wire         rd_flag1 = rd_fire && (rd_idx == IDX_FLAGS_ONE);
  wire         rd_flag2 = rd_fire && (rd_idx == IDX_FLAGS_TWO);
  wire         release_all = rd_fire && in_high && frz_r[high_g];

  // Conversion input
  wire         analog_mode = cfg1_r[CFG1_ANALOG_BIT];
  wire         int_pol_hi  = cfg1_r[CFG1_POL_BIT];
  wire         temp_conv   = (conv_in.chan == CH_INTTEMP) ||
                             ((conv_in.chan == CH_EXT_IN1) && !analog_mode);
  wire [7:0]   off_sel     = (conv_in.chan == CH_INTTEMP) ? off_int_r : off_ext_r;
  wire [9:0]   off_ext10   = {{2{off_sel[7]}}, off_sel};
  wire [9:0]   code_adj    = temp_conv ? (conv_in.code + off_ext10) : conv_in.code;
  wire [7:0]   code_hb     = code_adj[9:2];
  wire         fault_ev    = conv_in.valid && (conv_in.chan == CH_EXT_IN1) &&
                             !analog_mode && conv_in.fault;

  logic [NCH-1:0] ev_hi;
  logic [NCH-1:0] ev_lo;
  logic [NCH-1:0] cond_hi;
  logic [NCH-1:0] cond_lo;

  // Per-channel result, limits and snapshot
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    localparam logic [3:0] CH = 4'(g);
    wire sg  = (CH == CH_INTTEMP) || ((CH == CH_EXT_IN1) && !analog_mode);
    wire hit = conv_in.valid && (conv_in.chan == CH);

    assign ev_hi[g]    = hit && exceeds(code_hb, upper_r[g], sg);
    assign ev_lo[g]    = hit && !exceeds(code_hb, lower_r[g], sg);
    assign cond_hi[g]  = exceeds(res_r[g][9:2], upper_r[g], sg);
    assign cond_lo[g]  = !exceeds(res_r[g][9:2], lower_r[g], sg);
    assign shown_hi[g] = frz_r[grp_of(CH)] ? snap_r[g] : res_r[g][9:2];

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        res_r[g]   <= 10'h000;
        upper_r[g] <= UPPER_RST[g];
        lower_r[g] <= LOWER_RST[g];
        snap_r[g]  <= 8'h00;
      end else begin
        if (hit) begin
          res_r[g] <= code_adj;
        end
        if (wr_en && (wr_idx == UPPER_IDX[g])) begin
          upper_r[g] <= wbyte_r;
        end
        if (wr_en && (wr_idx == LOWER_IDX[g])) begin
          lower_r[g] <= wbyte_r;
        end
        if (lock_grp[grp_of(CH)]) begin
          snap_r[g] <= res_r[g][9:2];
        end
      end
    end
  end

  // Freeze control; lows are never frozen
  for (genvar k = 0; k < NGRP; k++) begin : g_lock
    assign lock_grp[k] = rd_fire && in_low && (low_g == 2'(k)) && !frz_r[k];
  end
  assign frz_nxt = swrst ? '0 : ((release_all ? '0 : frz_r) | lock_grp);

  // Status events and live conditions
  logic [7:0] st1_ev;
  logic [7:0] st2_ev;
  logic [7:0] st1_cond;
  logic [7:0] st2_cond;
  always_comb begin
    st1_ev   = 8'h00;
    st2_ev   = 8'h00;
    st1_cond = 8'h00;
    st2_cond = 8'h00;
    st1_ev[ST1_INT_HI]   = ev_hi[CH_INTTEMP];
    st1_ev[ST1_INT_LO]   = ev_lo[CH_INTTEMP];
    st1_ev[ST1_EXT_HI]   = analog_mode ? (ev_hi[CH_EXT_IN1] || ev_lo[CH_EXT_IN1])
                                       : ev_hi[CH_EXT_IN1];
    st1_ev[ST1_EXT_LO]   = !analog_mode && ev_lo[CH_EXT_IN1];
    st1_ev[ST1_FAULT]    = fault_ev;
    st2_ev[ST2_SUPPLY]   = ev_hi[CH_SUPPLY] || ev_lo[CH_SUPPLY];
    st1_cond[ST1_INT_HI] = cond_hi[CH_INTTEMP];
    st1_cond[ST1_INT_LO] = cond_lo[CH_INTTEMP];
    st1_cond[ST1_EXT_HI] = analog_mode ? (cond_hi[CH_EXT_IN1] || cond_lo[CH_EXT_IN1])
                                       : cond_hi[CH_EXT_IN1];
    st1_cond[ST1_EXT_LO] = !analog_mode && cond_lo[CH_EXT_IN1];
    st1_cond[ST1_FAULT]  = fault_r;
    st2_cond[ST2_SUPPLY] = cond_hi[CH_SUPPLY] || cond_lo[CH_SUPPLY];
    for (int i = 0; i < 3; i++) begin
      st1_ev[ST1_IN2 + i]   = ev_hi[CH_IN2 + 4'(i)] || ev_lo[CH_IN2 + 4'(i)];
      st1_cond[ST1_IN2 + i] = cond_hi[CH_IN2 + 4'(i)] || cond_lo[CH_IN2 + 4'(i)];
    end
    for (int i = 0; i < 4; i++) begin
      st2_ev[ST2_IN5 + i]   = ev_hi[CH_IN5 + 4'(i)] || ev_lo[CH_IN5 + 4'(i)];
      st2_cond[ST2_IN5 + i] = cond_hi[CH_IN5 + 4'(i)] || cond_lo[CH_IN5 + 4'(i)];
    end
  end

  // Sticky flags, set wins over clear
  wire [7:0] st1_set  = st1_ev & ~mask1_r;
  wire [7:0] st2_set  = st2_ev & ~mask2_r;
  wire [7:0] st1_keep = rd_flag1 ? (flags1_r & st1_cond) : flags1_r;
  wire [7:0] st2_keep = rd_flag2 ? (flags2_r & st2_cond) : flags2_r;
  assign flags1_nxt = (swrst ? 8'h00 : st1_keep) | st1_set;
  assign flags2_nxt = (swrst ? 8'h00 : st2_keep) | st2_set;
  wire irq_any = (|(flags1_r & ~mask1_r)) || (|(flags2_r & ~mask2_r));

  // Low-bit register packing
  logic [7:0] low_val [NGRP];
  assign low_val[0] = {4'h0, res_r[CH_INTTEMP][1:0], res_r[CH_SUPPLY][1:0]};
  assign low_val[1] = {res_r[5][1:0], res_r[4][1:0], res_r[3][1:0], res_r[2][1:0]};
  assign low_val[2] = {res_r[9][1:0], res_r[8][1:0], res_r[7][1:0], res_r[6][1:0]};

  // Read data select
  logic [7:0] rd_val;
  always_comb begin
    rd_val = 8'h00;
    if (in_high) begin
      rd_val = shown_hi[high_ch];
    end else if (in_low) begin
      rd_val = low_val[low_g];
    end
    case (rd_idx)
      IDX_FLAGS_ONE: rd_val = flags1_r;
      IDX_FLAGS_TWO: rd_val = flags2_r;
      IDX_CFG_ONE:   rd_val = cfg1_r;
      IDX_CFG_TWO:   rd_val = cfg2_r;
      IDX_CFG_THREE: rd_val = cfg3_r;
      IDX_MASK_ONE:  rd_val = mask1_r;
      IDX_MASK_TWO:  rd_val = mask2_r;
      IDX_OFF_INT:   rd_val = off_int_r;
      IDX_OFF_EXT:   rd_val = off_ext_r;
      IDX_DEVICE_IDENTIFIER: rd_val = DEVICE_IDENTIFIER_VAL;
      IDX_MAKER_ID:  rd_val = MAKER_ID_VAL;
      IDX_REVISION:  rd_val = REVISION_VAL;
      default: ;
    endcase
    for (int i = 0; i < NCH; i++) begin
      if (rd_idx == UPPER_IDX[i]) begin
        rd_val = upper_r[i];
      end
      if (rd_idx == LOWER_IDX[i]) begin
        rd_val = lower_r[i];
      end
    end
  end

  // Control, status and interrupt registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg1_r    <= RST_CFG_ONE;
      cfg2_r    <= RST_ZERO;
      cfg3_r    <= RST_ZERO;
      mask1_r   <= RST_ZERO;
      mask2_r   <= RST_ZERO;
      off_int_r <= RST_ZERO;
      off_ext_r <= RST_ZERO;
      flags1_r  <= RST_ZERO;
      flags2_r  <= RST_ZERO;
      fault_r   <= 1'b0;
      frz_r     <= '0;
      irq_r     <= 1'b0;
    end else begin
      if (wr_en) begin
        case (wr_idx)
          IDX_CFG_ONE:   cfg1_r    <= wbyte_r;
          IDX_CFG_TWO:   cfg2_r    <= wbyte_r;
          IDX_CFG_THREE: cfg3_r    <= wbyte_r & CFG3_KEEP;
          IDX_MASK_ONE:  mask1_r   <= wbyte_r;
          IDX_MASK_TWO:  mask2_r   <= wbyte_r;
          IDX_OFF_INT:   off_int_r <= wbyte_r;
          IDX_OFF_EXT:   off_ext_r <= wbyte_r;
          default: ;
        endcase
      end
      if (conv_in.valid && (conv_in.chan == CH_EXT_IN1)) begin
        fault_r <= conv_in.fault && !analog_mode;
      end
      flags1_r <= flags1_nxt;
      flags2_r <= flags2_nxt;
      frz_r    <= frz_nxt;
      irq_r    <= int_pol_hi ? irq_any : !irq_any;
    end
  end

  // Write channel handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      awaddr_r  <= '0;
      wbyte_r   <= 8'h00;
      wstrb0_r  <= 1'b0;
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_have_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
        awready_r <= 1'b0;
      end else if (wr_fire) begin
        aw_have_r <= 1'b0;
      end
      if (w_take) begin
        w_have_r <= 1'b1;
        wbyte_r  <= s_axi_wdata[7:0];
        wstrb0_r <= s_axi_wstrb[0];
        wready_r <= 1'b0;
      end else if (wr_fire) begin
        w_have_r <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_r <= 1'b1;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  // Read channel handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
    end else if (rd_fire) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= {24'h000000, rd_val};
    end else if (rvalid_r && s_axi_rready) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = RESP_OKAY;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = RESP_OKAY;
  assign irq_out       = irq_r;

endmodule : mrl_regs

// ===== verilog/mrl_pkg.sv
package mrl_pkg;

  // Bus geometry
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam logic [1:0] RESP_OKAY = 2'b00;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_FLAGS_ONE      = 8'h00;
  localparam logic [7:0] IDX_FLAGS_TWO      = 8'h01;
  localparam logic [7:0] IDX_LOW_INT_SUPPLY = 8'h03;
  localparam logic [7:0] IDX_LOW_EXT_IN1TO4 = 8'h04;
  localparam logic [7:0] IDX_LOW_IN5TO8     = 8'h05;
  localparam logic [7:0] IDX_HIGH_SUPPLY    = 8'h06;
  localparam logic [7:0] IDX_HIGH_IN8       = 8'h0F;
  localparam logic [7:0] IDX_CFG_ONE        = 8'h18;
  localparam logic [7:0] IDX_CFG_TWO        = 8'h19;
  localparam logic [7:0] IDX_CFG_THREE      = 8'h1A;
  localparam logic [7:0] IDX_MASK_ONE       = 8'h1D;
  localparam logic [7:0] IDX_MASK_TWO       = 8'h1E;
  localparam logic [7:0] IDX_OFF_INT        = 8'h1F;
  localparam logic [7:0] IDX_OFF_EXT        = 8'h20;
  localparam logic [7:0] IDX_DEVICE_IDENTIFIER      = 8'h4D;
  localparam logic [7:0] IDX_MAKER_ID       = 8'h4E;
  localparam logic [7:0] IDX_REVISION       = 8'h4F;
  localparam logic [7:0] IDX_LOCK_STATE     = 8'h7F;

  // Channels: supply, internal temp, ext temp or input 1, inputs 2 to 8
  localparam int NCH  = 10;
  localparam int NGRP = 3;
  localparam logic [3:0] CH_SUPPLY  = 4'h0;
  localparam logic [3:0] CH_INTTEMP = 4'h1;
  localparam logic [3:0] CH_EXT_IN1 = 4'h2;
  localparam logic [3:0] CH_IN2     = 4'h3;
  localparam logic [3:0] CH_IN5     = 4'h6;
  localparam logic [3:0] GRP1_FIRST = 4'h2;
  localparam logic [3:0] GRP2_FIRST = 4'h6;

  // Limit register indices and reset values per channel
  localparam logic [7:0] UPPER_IDX [NCH] = '{8'h23, 8'h25, 8'h27, 8'h2B, 8'h2D,
                                             8'h2F, 8'h31, 8'h33, 8'h35, 8'h37};
  localparam logic [7:0] LOWER_IDX [NCH] = '{8'h24, 8'h26, 8'h28, 8'h2C, 8'h2E,
                                             8'h30, 8'h32, 8'h34, 8'h36, 8'h38};
  localparam logic [7:0] UPPER_RST [NCH] = '{8'hC7, 8'h64, 8'hFF, 8'hFF, 8'hFF,
                                             8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  localparam logic [7:0] LOWER_RST [NCH] = '{8'h62, 8'hC9, 8'h00, 8'h00, 8'h00,
                                             8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  // Reset values and control fields
  localparam logic [7:0] RST_CFG_ONE  = 8'h08;
  localparam logic [7:0] RST_ZERO     = 8'h00;
  localparam int CFG1_ANALOG_BIT      = 1;
  localparam int CFG1_POL_BIT         = 3;
  localparam int CFG3_SWRST_BIT       = 7;
  localparam logic [7:0] CFG3_KEEP    = 8'h7F;

  // Status bit positions
  localparam int ST1_INT_HI = 0;
  localparam int ST1_INT_LO = 1;
  localparam int ST1_EXT_HI = 2;
  localparam int ST1_EXT_LO = 3;
  localparam int ST1_FAULT  = 4;
  localparam int ST1_IN2    = 5;
  localparam int ST2_IN5    = 0;
  localparam int ST2_SUPPLY = 4;

  // One conversion result from the converter
  typedef struct packed {
    logic       valid;
    logic [3:0] chan;
    logic [9:0] code;
    logic       fault;
  } mrl_conv_s;

endpackage : mrl_pkg

// ===== testbench/mrl_regs_properties.sv
`timescale 1ns/1ps
module mrl_regs_properties (
  // Clock and reset
  input wire logic                       aclk,
  input wire logic                       aresetn,
  // Write channels
  input wire logic                       s_axi_awvalid,
  input wire logic                       s_axi_awready,
  input wire logic                       s_axi_wvalid,
  input wire logic                       s_axi_wready,
  input wire logic [1:0]                 s_axi_bresp,
  input wire logic                       s_axi_bvalid,
  // Read channels
  input wire logic [mrl_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic                       s_axi_arvalid,
  input wire logic                       s_axi_arready,
  input wire logic [mrl_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic                       s_axi_rvalid,
  input wire logic                       s_axi_rready,
  // Results and interrupt
  input wire mrl_pkg::mrl_conv_s         conv_in,
  input wire logic                       irq_out
);
  import mrl_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Reserved and always-zero places
  wire [7:0] ridx = s_axi_araddr[9:2];
  wire       rsvd = (ridx == 8'h02) || (ridx[7:3] == 5'h02) ||
                    (ridx >= 8'h39 && ridx <= 8'h4C) || (ridx >= 8'h50);
  wire       ar_go = s_axi_arvalid && s_axi_arready;
  a_read_answer: assert property (ar_go |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer missing");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  a_rdata_done: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid && s_axi_arready) else $error("read not closed");
  a_byte_wide: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_reserved_zero: assert property (ar_go && rsvd |=> s_axi_rdata == 32'h0)
    else $error("reserved read not zero");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##2 s_axi_bvalid && s_axi_bresp == RESP_OKAY) else $error("no write answer");
  a_aw_busy: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2])
    else $error("second write taken early");
  a_irq_reset: assert property ($rose(aresetn) |-> irq_out == 1'b0)
    else $error("interrupt active after reset");
  c_conv: cover property (conv_in.valid && conv_in.chan == CH_INTTEMP);
  c_read_flags: cover property (ar_go && ridx == IDX_FLAGS_ONE);
  c_irq_rise: cover property ($rose(irq_out));
endmodule : mrl_regs_properties

bind mrl_regs mrl_regs_properties u_props (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .conv_in(conv_in), .irq_out(irq_out));

// ===== testbench/mrl_conv_model.sv
`timescale 1ns/1ps
module mrl_conv_model (
  // Clock
  input wire logic          aclk,
  // Result stream
  output mrl_pkg::mrl_conv_s conv_in
);
  import mrl_pkg::*;
  initial conv_in = '0;
  // One result for one cycle, then scrambled payload
  task automatic send(input logic [3:0] ch, input logic [9:0] cd, input logic f);
    @(posedge aclk);
    conv_in <= '{valid: 1'b1, chan: ch, code: cd, fault: f};
    @(posedge aclk);
    conv_in <= '{valid: 1'b0, chan: ~ch, code: ~cd, fault: ~f};
  endtask : send
endmodule : mrl_conv_model

// ===== testbench/monitor_result_limit_regs_tb_top.sv
`timescale 1ns/1ps
module monitor_result_limit_regs_tb_top;
  import mrl_pkg::*;
  localparam logic [7:0] DEV_ID = 8'h6B;  // Arbitrary value
  localparam logic [7:0] MAK_ID = 8'h2D;  // Arbitrary value
  localparam logic [7:0] REV_ID = 8'h03;  // Arbitrary value
  logic              aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready, irq_out;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp;
  logic [2:0]        frz;
  logic [31:0]       r;
  mrl_conv_s         conv_in;
  int                err_count, checks, seed, cyc, flags, flt;
  int                rg [256];
  int                res [NCH];
  int                snap [NCH];
  logic [7:0]        hb [5] = '{8'h10, 8'h11, 8'hF0, 8'hF1, 8'h80};

  mrl_regs #(.DEVICE_IDENTIFIER_VAL(DEV_ID), .MAKER_ID_VAL(MAK_ID), .REVISION_VAL(REV_ID)) uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'b000),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'b000), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .conv_in(conv_in), .irq_out(irq_out));
  mrl_conv_model u_conv (.aclk(aclk), .conv_in(conv_in));

  function automatic int sx(int v);
    return (v >= 128) ? v - 256 : v;
  endfunction : sx
  function automatic int msk();
    return (rg[IDX_MASK_TWO] << 8) | rg[IDX_MASK_ONE];
  endfunction : msk
  // Condition bits of one channel in status layout
  function automatic int cnd(int ch);
    int v, hi, lo, sg;
    sg = (ch == 1) || (ch == 2 && rg[IDX_CFG_ONE][CFG1_ANALOG_BIT] == 0);
    v = res[ch] >> 2;
    hi = sg ? sx(v) > sx(rg[UPPER_IDX[ch]]) : v > rg[UPPER_IDX[ch]];
    lo = sg ? sx(v) <= sx(rg[LOWER_IDX[ch]]) : v <= rg[LOWER_IDX[ch]];
    if (ch == 0) return (hi | lo) << 12;
    if (ch == 1) return hi | (lo << 1);
    if (ch == 2 && sg) return (hi << 2) | (lo << 3) | (flt << 4);
    return (hi | lo) << ((ch == 2) ? 2 : ch + 2);
  endfunction : cnd
  function automatic int live();
    int c = 0;
    for (int ch = 0; ch < NCH; ch++) c |= cnd(ch);
    return c | (flt << 4);
  endfunction : live
  function automatic void m_conv(int ch, int cd, int f);
    if (ch >= NCH) return;
    if (ch == 1 || (ch == 2 && rg[IDX_CFG_ONE][CFG1_ANALOG_BIT] == 0))
      cd = (cd + sx(rg[(ch == 1) ? IDX_OFF_INT : IDX_OFF_EXT])) & 1023;
    res[ch] = cd;
    if (ch == 2) flt = f && (rg[IDX_CFG_ONE][CFG1_ANALOG_BIT] == 0);
    flags |= cnd(ch) & ~msk();
  endfunction : m_conv
  function automatic int m_read(int idx);
    int v, b, n;
    v = rg[idx];
    b = (idx == 3) ? 0 : (idx == 4) ? 2 : 6;
    n = (idx == 3) ? 2 : 4;
    if (idx < 2) begin
      v = (flags >> (8 * idx)) & 255;
      flags &= ~(~live() & (255 << (8 * idx)));
    end else if (idx >= 3 && idx <= 5) begin
      v = 0;
      for (int k = 0; k < n; k++) v |= (res[b + k] & 3) << (2 * k);
      if (!frz[idx - 3]) for (int k = 0; k < n; k++) snap[b + k] = res[b + k];
      frz[idx - 3] = 1'b1;
    end else if (idx >= 6 && idx <= 15) begin
      b = (idx < 8) ? 0 : (idx < 12) ? 1 : 2;
      v = (frz[b] ? snap[idx - 6] : res[idx - 6]) >> 2;
      if (frz[b]) frz = 3'b000;
    end else if (idx == IDX_CFG_THREE) v &= 8'h7F;
    return v;
  endfunction : m_read
  function automatic void m_write(int idx, int d, logic [3:0] st);
    if (st[0] && (idx inside {[8'h18:8'h1A], [8'h1D:8'h20], [8'h23:8'h28], [8'h2B:8'h38]}))
      rg[idx] = d & 255;
    if (st[0] && idx == IDX_CFG_THREE && d[CFG3_SWRST_BIT]) begin
      flags = 0;
      frz = 3'b000;
    end
  endfunction : m_write
  task automatic m_reset;
    foreach (rg[i]) rg[i] = 0;
    foreach (res[i]) res[i] = 0;
    for (int c = 0; c < NCH; c++) begin
      rg[UPPER_IDX[c]] = UPPER_RST[c];
      rg[LOWER_IDX[c]] = LOWER_RST[c];
    end
    rg[IDX_CFG_ONE] = RST_CFG_ONE;
    rg[IDX_DEVICE_IDENTIFIER] = DEV_ID;
    rg[IDX_MAKER_ID] = MAK_ID;
    rg[IDX_REVISION] = REV_ID;
    flags = 0;
    frz = 3'b000;
    flt = 0;
  endtask : m_reset
  task automatic chk_rd(input logic [31:0] got, input int exp);
    checks++;
    if (got !== 32'(exp)) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, 32'(exp));
    end
  endtask : chk_rd
  task automatic chk_irq;
    logic e;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    e = ((flags & ~msk()) != 0) == rg[IDX_CFG_ONE][CFG1_POL_BIT];
    checks++;
    if (irq_out !== e) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, irq_out, e);
    end
  endtask : chk_irq
  task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [3:0] st);
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= d;
    wstrb <= st;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    m_write(idx, d, st);
    chk_irq();
  endtask : wr
  task automatic rd(input logic [7:0] idx);
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    @(posedge aclk);
    rready <= 1'b1;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    chk_rd(rdata, m_read(idx));
    chk_rd({30'h0, rresp}, RESP_OKAY);
    chk_irq();
  endtask : rd
  task automatic cv(input logic [3:0] ch, input logic [9:0] cd, input logic f);
    u_conv.send(ch, cd, f);
    m_conv(ch, cd, f);
    chk_irq();
  endtask : cv
  task automatic wrap_up;
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      wrap_up();
    end
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, wstrb} = '0;
    {err_count, checks, cyc} = '0;
    seed = 98808;
    m_reset();
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values, reserved places, identity
    for (int i = 0; i < 256; i++) rd(i[7:0]);
    // Random traffic
    for (int i = 0; i < 400; i++) begin
      r = $random(seed);
      case (r[1:0])
        2'd0: cv(r[5:2], r[15:6], r[16]);
        2'd1: rd({3'b000, r[6:2]});
        2'd2: wr({2'b00, r[7:2]}, {24'h0, r[31:24]}, r[11:8]);
        default: rd({7'h00, r[2]});
      endcase
    end
    // Second reset mid-run
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    m_reset();
    aresetn <= 1'b1;
    // Limit boundaries, signed and unsigned
    for (int c = 1; c < 4; c += 2) begin
      wr(UPPER_IDX[c], 32'h10, 4'h1);
      wr(LOWER_IDX[c], 32'hF0, 4'h1);
      for (int k = 0; k < 5; k++) begin
        cv(c[3:0], {hb[k], 2'b11}, 1'b0);
        rd(IDX_FLAGS_ONE);
        rd(IDX_FLAGS_ONE);
      end
    end
    // Mask and polarity
    wr(IDX_MASK_ONE, 32'hFF, 4'h1);
    cv(4'h1, 10'h100, 1'b0);
    rd(IDX_FLAGS_ONE);
    wr(IDX_CFG_ONE, 32'h00, 4'h1);
    wr(IDX_MASK_ONE, 32'h00, 4'h1);
    cv(4'h1, 10'h100, 1'b0);
    // Offset
    wr(IDX_OFF_INT, 32'hFC, 4'h1);
    cv(4'h1, 10'h002, 1'b0);
    rd(8'h07);
    // Freeze and release
    cv(4'h0, 10'h155, 1'b0);
    rd(IDX_LOW_INT_SUPPLY);
    cv(4'h0, 10'h2AA, 1'b0);
    cv(4'h1, 10'h0F1, 1'b0);
    rd(IDX_LOW_EXT_IN1TO4);
    rd(IDX_HIGH_SUPPLY);
    rd(8'h07);
    rd(8'h08);
    cv(4'h2, 10'h1E7, 1'b1);
    rd(IDX_LOW_EXT_IN1TO4);
    rd(8'h08);
    rd(IDX_FLAGS_ONE);
    // Soft reset and masked strobe
    wr(IDX_CFG_THREE, 32'h80, 4'h1);
    rd(IDX_FLAGS_ONE);
    rd(IDX_CFG_THREE);
    wr(8'h23, 32'h55, 4'h0);
    rd(8'h23);
    wrap_up();
  end
endmodule : monitor_result_limit_regs_tb_top
